//--- inc/cawd_pkg.sv
/*
  Constants, field layout, register offsets and carrier types shared by the
  counter array modulation and watchdog block.
  Assumes a 32-bit classic Wishbone slave with byte registers in bits 7:0.
*/
package cawd_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_MODE = 8'h04;
  localparam logic [7:0] ADR_PWMCFG = 8'h08;
  localparam logic [7:0] ADR_CNT_LO = 8'h0c;
  localparam logic [7:0] ADR_CNT_HI = 8'h10;
  localparam logic [7:0] ADR_MOD_BASE = 8'h20;
  localparam logic [7:0] ADR_CMPL_BASE = 8'h30;
  localparam logic [7:0] ADR_CMPH_BASE = 8'h40;

  // ----------------------------------------------------------------
  // Counts and field positions
  // ----------------------------------------------------------------
  localparam int NUM_MODS = 3;
  localparam int WD_MOD = 2;
  localparam int RELOAD_W = 11;
  localparam int MB_PWM16 = 7, MB_ECOM = 6, MB_MAT = 3, MB_PWM = 1, MB_ECCF = 0;
  localparam int CB_CF = 7, CB_CR = 6;
  localparam int MD_IDLE_SUSPEND = 7, MD_WATCHDOG_ENABLE = 6, MD_WATCHDOG_LOCK = 5, MD_CPS_HI = 3, MD_CPS_LO = 1, MD_ECF = 0;
  localparam int PB_RELOAD_SELECT = 7, PB_ECOV = 6, PB_CYCLE_OVERFLOW_FLAG = 5;
  localparam logic [1:0] CYCLE_LENGTH_FIELD_8 = 2'h0;
  localparam logic [7:0] ECOM_MASK = 8'h40;
  localparam logic [15:0] FULL_MASK = 16'hffff;
  localparam logic [7:0] LOW_ONES = 8'hff;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic WATCHDOG_ENABLE_RST = 1'b1;
  localparam logic [2:0] CPS_RST = 3'h0;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [7:0] MODE_RST = 8'h00;

  // Software write strobes toward one compare module
  typedef struct packed {
    logic mode_we;
    logic lo_we;
    logic hi_we;
    logic [7:0] wdat;
  } cawd_swr_t;

  // Shared cycle and reload configuration plus the per-module watchdog mode flag
  typedef struct packed {
    logic [1:0] cycle_length_field;
    logic reload_select;
    logic wd_mode;
  } cawd_cfg_t;

  // Mask of the counter bits that make one modulation cycle
  function automatic logic [15:0] cyc_mask(input logic [1:0] cycle_length_field);
    unique case (cycle_length_field)
      2'h0: cyc_mask = 16'h00ff;
      2'h1: cyc_mask = 16'h01ff;
      2'h2: cyc_mask = 16'h03ff;
      default: cyc_mask = 16'h07ff;
    endcase
  endfunction

  // Byte offset of the register of module idx in a bank
  function automatic logic [7:0] mod_adr(input logic [7:0] base, input int idx);
    mod_adr = base + 8'(idx * 4);
  endfunction

endpackage

//--- rtl/cawd_module.sv
/*
  One compare module: mode register, compare value, auto-reload value,
  modulation output and match event.
  Assumes the shared counter, tick and write strobes come from cawd_top.
*/
`timescale 1ns/100ps
module cawd_module (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Shared counter
  input wire logic tick_i,
  input wire logic [15:0] count_i,
  // Configuration and software writes
  input wire cawd_pkg::cawd_cfg_t cfg_i,
  input wire cawd_pkg::cawd_swr_t swr_i,
  // Read back and events
  output logic [7:0] mode_o,
  output logic [7:0] rd_lo_o,
  output logic [7:0] rd_hi_o,
  output logic [15:0] cmp_o,
  output logic pin_o,
  output logic match_o
);
  logic [cawd_pkg::RELOAD_W-1:0] reload;
  wire pwm_on = mode_o[cawd_pkg::MB_PWM] & ~cfg_i.wd_mode;
  wire is16 = pwm_on & mode_o[cawd_pkg::MB_PWM16];
  wire is8 = pwm_on & ~is16 & (cfg_i.cycle_length_field == cawd_pkg::CYCLE_LENGTH_FIELD_8);
  wire isn = pwm_on & ~is16 & ~is8;
  wire ecom = mode_o[cawd_pkg::MB_ECOM];
  wire reload_select_map = cfg_i.reload_select & isn;
  wire [15:0] mask = (pwm_on & ~is16) ? cawd_pkg::cyc_mask(cfg_i.cycle_length_field) : cawd_pkg::FULL_MASK;
  wire [15:0] next_count = count_i + 16'h0001;
  wire [15:0] reload16 = {{(16 - cawd_pkg::RELOAD_W){1'b0}}, reload};
  wire ovf = tick_i & ((count_i & mask) == mask);
  // Compare against the value that the overflow reloads in the same step
  wire [15:0] eff_cmp = (ovf & is8) ? {cmp_o[15:8], cmp_o[15:8]} : (ovf & isn) ? reload16 : cmp_o;
  wire hit = tick_i & ((next_count & mask) == (eff_cmp & mask));
  wire [7:0] wd_hi = count_i[15:8] + cmp_o[7:0];
  wire next_match = ~cfg_i.wd_mode & ecom & mode_o[cawd_pkg::MB_MAT] & hit;
  // Match sets the pin, cycle overflow clears it, a cleared comparator holds it low
  wire next_pin = (~pwm_on | ~ecom) ? 1'b0 : hit ? 1'b1 : ovf ? 1'b0 : pin_o;
  wire [7:0] next_lo = (swr_i.lo_we & ~reload_select_map) ? swr_i.wdat : (ovf & is8) ? cmp_o[15:8]
                     : (ovf & isn) ? reload[7:0] : cmp_o[7:0];
  wire [7:0] next_hi = (swr_i.hi_we & cfg_i.wd_mode) ? wd_hi : (swr_i.hi_we & ~reload_select_map) ? swr_i.wdat
                     : (ovf & isn) ? reload16[15:8] : cmp_o[15:8];
  wire [cawd_pkg::RELOAD_W-1:0] next_reload = {(swr_i.hi_we & reload_select_map) ? swr_i.wdat[2:0] : reload[10:8],
                                               (swr_i.lo_we & reload_select_map) ? swr_i.wdat : reload[7:0]};
  wire [7:0] next_mode = swr_i.mode_we ? swr_i.wdat : swr_i.lo_we ? (mode_o & ~cawd_pkg::ECOM_MASK)
                       : swr_i.hi_we ? (mode_o | cawd_pkg::ECOM_MASK) : mode_o;
  assign rd_lo_o = reload_select_map ? reload[7:0] : cmp_o[7:0];
  assign rd_hi_o = reload_select_map ? reload16[15:8] : cmp_o[15:8];

  // State update, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_o <= cawd_pkg::MODE_RST;
      cmp_o <= cawd_pkg::CMP_RST;
      reload <= '0;
      pin_o <= 1'b0;
      match_o <= 1'b0;
    end else if (ce_i) begin
      mode_o <= next_mode;
      cmp_o <= {next_hi, next_lo};
      reload <= next_reload;
      pin_o <= next_pin;
      match_o <= next_match;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_hi_write;
    ce_i && swr_i.hi_we && !cfg_i.wd_mode;
  endsequence
  a_lo_clears_ecom: assert property (ce_i && swr_i.lo_we |=> !mode_o[cawd_pkg::MB_ECOM])
    else $error("Low byte write left comparator enabled");
  a_hi_sets_ecom: assert property (s_hi_write |=> mode_o[cawd_pkg::MB_ECOM])
    else $error("High byte write did not enable comparator");
  a_wd_update_byte: assert property (ce_i && swr_i.hi_we && cfg_i.wd_mode |=>
    cmp_o[15:8] == 8'($past(count_i[15:8]) + $past(cmp_o[7:0]))) else $error("Watchdog update value wrong");
  a_pin_low_off: assert property (ce_i && pwm_on && !ecom |=> !pin_o)
    else $error("Output high with comparator off");
  a_pin_rise_match: assert property (ce_i && pwm_on && ecom && hit |=> pin_o ##0 $rose(pin_o) || $past(pin_o))
    else $error("Output not high after match");
  a_reload_eight: assert property (ce_i && ovf && is8 && !swr_i.lo_we |=> cmp_o[7:0] == $past(cmp_o[15:8]))
    else $error("Low byte not reloaded at overflow");
endmodule

//--- rtl/cawd_top.sv
/*
  Counter array modulation and watchdog block: shared 16-bit counter, three
  compare modules, control/mode/config registers and the watchdog of module 2.
  Assumes a classic Wishbone master on clk_i and a clock enable that marks
  the selected counter clock; the clock divider itself lives outside.
*/
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps

module cawd_top (
  // Clock, reset and clock enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // CPU idle indication, same clock domain
  input wire logic cpu_idle_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Module output pins
  output logic [2:0] pin_o,
  // Counter clock selection toward the divider
  output logic [2:0] clock_select_o,
  // Watchdog reset request
  output logic wd_reset_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] count;
  logic cf;
  logic cr;
  logic [2:0] ccf;
  logic idle_suspend;
  logic watchdog_enable;
  logic watchdog_lock;
  logic ecf;
  logic reload_select;
  logic ecov;
  logic cycle_overflow_flag;
  logic [1:0] cycle_length_field;

  // Per-module wiring
  cawd_pkg::cawd_swr_t swr [cawd_pkg::NUM_MODS];
  logic [7:0] mod_mode [cawd_pkg::NUM_MODS];
  logic [7:0] mod_lo [cawd_pkg::NUM_MODS];
  logic [7:0] mod_hi [cawd_pkg::NUM_MODS];
  logic [15:0] mod_cmp [cawd_pkg::NUM_MODS];
  logic [7:0] mod_rd [cawd_pkg::NUM_MODS];
  logic [2:0] match;
  logic [2:0] mod_pin;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------

  // A write lands at the edge where the master sees ack high
  wire req = cyc_i & stb_i;
  wire wr = req & we_i & ack_o & sel_i[0];
  wire [7:0] wdat = dat_i[7:0];
  wire hit_ctrl = adr_i == cawd_pkg::ADR_CTRL;
  wire hit_mode = adr_i == cawd_pkg::ADR_MODE;
  wire hit_pwm = adr_i == cawd_pkg::ADR_PWMCFG;
  wire hit_cnt_lo = adr_i == cawd_pkg::ADR_CNT_LO;
  wire hit_cnt_hi = adr_i == cawd_pkg::ADR_CNT_HI;
  wire wr_ctrl = wr & hit_ctrl;
  wire wr_mode = wr & hit_mode;
  wire wr_pwm = wr & hit_pwm;

  // ----------------------------------------------------------------
  // Watchdog enable and restrictions
  // ----------------------------------------------------------------

  // Either bit turns the watchdog on; lock cannot be cleared by software
  wire wd_en = watchdog_enable | watchdog_lock;
  // Counter runs by software or watchdog, unless idle suspend holds it
  wire run = (cr | wd_en) & ~(idle_suspend & cpu_idle_i);
  wire tick = run;
  wire wr_cnt_lo = wr & hit_cnt_lo & ~wd_en;
  wire wr_cnt_hi = wr & hit_cnt_hi & ~wd_en;
  wire wr_cfg_frozen = wr_mode & ~wd_en;

  // ----------------------------------------------------------------
  // Counter and shared flags
  // ----------------------------------------------------------------

  // Next counter value: software load when allowed, else count
  wire [15:0] next_count = wr_cnt_lo ? {count[15:8], wdat} : wr_cnt_hi ? {wdat, count[7:0]}
                         : tick ? count + 16'h0001 : count;
  wire [15:0] cyc_msk = cawd_pkg::cyc_mask(cycle_length_field);
  wire cf_set = tick & (count == cawd_pkg::FULL_MASK);
  wire cycle_overflow_flag_set = tick & ((count & cyc_msk) == cyc_msk);
  // Set wins over a software clear in the same cycle
  wire next_cf = cf_set | (wr_ctrl ? wdat[cawd_pkg::CB_CF] : cf);
  wire next_cycle_overflow_flag = cycle_overflow_flag_set | (wr_pwm ? wdat[cawd_pkg::PB_CYCLE_OVERFLOW_FLAG] : cycle_overflow_flag);
  wire [2:0] next_ccf = match | (wr_ctrl ? wdat[2:0] : ccf);

  // ----------------------------------------------------------------
  // Watchdog reset sources
  // ----------------------------------------------------------------

  // Low byte overflow while module 2 high byte matches counter high byte
  wire wd_match = tick & (count[7:0] == cawd_pkg::LOW_ONES)
                & (mod_cmp[cawd_pkg::WD_MOD][15:8] == count[15:8]);
  // Software forcing through the module 2 flag
  wire wd_force = wr_ctrl & wdat[cawd_pkg::WD_MOD];
  wire wd_fire = wd_en & (wd_match | wd_force);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------

  // Register images; unused bits read zero
  wire [7:0] rd_ctrl = {cf, cr, 3'h0, ccf};
  wire [7:0] rd_mode = {idle_suspend, watchdog_enable, watchdog_lock, 1'b0, clock_select_o, ecf};
  wire [7:0] rd_pwm = {reload_select, ecov, cycle_overflow_flag, 3'h0, cycle_length_field};
  wire [7:0] rd_mods = mod_rd[0] | mod_rd[1] | mod_rd[2];
  wire [7:0] rd_byte = hit_ctrl ? rd_ctrl : hit_mode ? rd_mode : hit_pwm ? rd_pwm
                     : hit_cnt_lo ? count[7:0] : hit_cnt_hi ? count[15:8] : rd_mods;

  // ----------------------------------------------------------------
  // Compare modules
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < cawd_pkg::NUM_MODS; g++) begin : gen_mod
      wire hit_m = adr_i == cawd_pkg::mod_adr(cawd_pkg::ADR_MOD_BASE, g);
      wire hit_l = adr_i == cawd_pkg::mod_adr(cawd_pkg::ADR_CMPL_BASE, g);
      wire hit_h = adr_i == cawd_pkg::mod_adr(cawd_pkg::ADR_CMPH_BASE, g);
      wire wd_here = (g == cawd_pkg::WD_MOD) && wd_en;
      // Direct writes to the mode register of the watchdog module are blocked while it guards
      wire mode_we = wr & hit_m & ~wd_here;
      // Per-module decode and write strobes
      assign swr[g] = {mode_we, wr & hit_l, wr & hit_h, wdat};
      assign mod_rd[g] = hit_m ? mod_mode[g] : hit_l ? mod_lo[g] : hit_h ? mod_hi[g] : 8'h00;

      cawd_module u_mod (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_i(tick),
        .count_i(count),
        .cfg_i({cycle_length_field, reload_select, wd_here}),
        .swr_i(swr[g]),
        .mode_o(mod_mode[g]),
        .rd_lo_o(mod_lo[g]),
        .rd_hi_o(mod_hi[g]),
        .cmp_o(mod_cmp[g]),
        .pin_o(mod_pin[g]),
        .match_o(match[g])
      );
    end
  endgenerate

  // Pins come straight from the module output flip-flops
  assign pin_o = mod_pin;

  // ----------------------------------------------------------------
  // Wishbone answer
  // ----------------------------------------------------------------

  // Ack one cycle after the request is seen, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else if (ce_i) begin
      ack_o <= req & ~ack_o;
      dat_o <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // Counter and flags
  // ----------------------------------------------------------------

  // Counter, overflow flags and module flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= cawd_pkg::CNT_RST;
      cf <= 1'b0;
      cycle_overflow_flag <= 1'b0;
      ccf <= 3'h0;
    end else if (ce_i) begin
      count <= next_count;
      cf <= next_cf;
      cycle_overflow_flag <= next_cycle_overflow_flag;
      ccf <= next_ccf;
    end
  end

  // ----------------------------------------------------------------
  // Control and configuration
  // ----------------------------------------------------------------

  // Run bit stores only what software wrote
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cr <= 1'b0;
      reload_select <= 1'b0;
      ecov <= 1'b0;
      cycle_length_field <= cawd_pkg::CYCLE_LENGTH_FIELD_8;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        cr <= wdat[cawd_pkg::CB_CR];
      end
      if (wr_pwm) begin
        reload_select <= wdat[cawd_pkg::PB_RELOAD_SELECT];
        ecov <= wdat[cawd_pkg::PB_ECOV];
        cycle_length_field <= wdat[1:0];
      end
    end
  end

  // Mode register: watchdog on after reset, lock sticky until reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      watchdog_enable <= cawd_pkg::WATCHDOG_ENABLE_RST;
      watchdog_lock <= 1'b0;
      idle_suspend <= 1'b0;
      clock_select_o <= cawd_pkg::CPS_RST;
      ecf <= 1'b0;
    end else if (ce_i) begin
      if (wr_mode) begin
        watchdog_enable <= wdat[cawd_pkg::MD_WATCHDOG_ENABLE];
        watchdog_lock <= watchdog_lock | wdat[cawd_pkg::MD_WATCHDOG_LOCK];
        ecf <= wdat[cawd_pkg::MD_ECF];
      end
      if (wr_cfg_frozen) begin
        idle_suspend <= wdat[cawd_pkg::MD_IDLE_SUSPEND];
        clock_select_o <= wdat[cawd_pkg::MD_CPS_HI:cawd_pkg::MD_CPS_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Watchdog reset request
  // ----------------------------------------------------------------

  // One-cycle pulse toward the system reset logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_reset_o <= 1'b0;
    end else if (ce_i) begin
      wd_reset_o <= wd_fire;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wd_request;
    ce_i && wd_en && wr_ctrl && wdat[cawd_pkg::WD_MOD];
  endsequence

  a_wd_force_reset: assert property (s_wd_request |=> wd_reset_o)
    else $error("Forced watchdog reset missing");
  a_wd_pulse_single: assert property (ce_i && wd_reset_o |=> !wd_reset_o)
    else $error("Watchdog reset longer than one cycle");
  a_wd_reset_cause: assert property (wd_reset_o |-> $past(wd_en))
    else $error("Watchdog reset while disabled");
  a_wd_counter_run: assert property (ce_i && wd_en && !(idle_suspend && cpu_idle_i) |=>
    count == 16'($past(count) + 16'h0001)) else $error("Counter not forced on by watchdog");
  a_wd_cfg_frozen: assert property (wd_en |=> $stable(clock_select_o) && $stable(idle_suspend))
    else $error("Clock or idle bits changed under watchdog");
  a_lock_keeps_on: assert property (watchdog_lock |=> watchdog_lock && wd_en)
    else $error("Locked watchdog was disabled");
  a_cf_overflow: assert property (ce_i && tick && count == cawd_pkg::FULL_MASK |=> cf && count == 16'h0000)
    else $error("Counter overflow flag not set");
  a_cycle_overflow_flag_flag: assert property (ce_i && cycle_overflow_flag_set |=> cycle_overflow_flag)
    else $error("Cycle overflow flag not set");
  a_flag_held: assert property (ce_i && cycle_overflow_flag && !wr_pwm |=> cycle_overflow_flag)
    else $error("Cycle overflow flag cleared by hardware");
  a_ack_single: assert property (ce_i && ack_o |=> !ack_o)
    else $error("Ack held for more than one cycle");
endmodule

//--- tb/cawd_load_model.sv
/*
  Load on the three module output pins: counts the cycles each pin is high.
  Assumes the pins are registered levels in the clk_i domain.
*/
`timescale 1ns/100ps
module cawd_load_model (
  // Clock and window control
  input wire logic clk_i,
  input wire logic clr_i,
  // Pins and results
  input wire logic [2:0] pin_i,
  output logic [15:0] hi_cnt_o [3]
);
  // One high-time counter per pin; clear opens a new window
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (clr_i) begin
        hi_cnt_o[i] <= 16'h0000;
      end else if (pin_i[i]) begin
        hi_cnt_o[i] <= hi_cnt_o[i] + 16'h0001;
      end
    end
  end
endmodule

//--- tb/cawd_top_tb_top.sv
/*
  Bench for cawd_top: Wishbone tasks, watchdog and modulation sequences.
  Assumes the package and the load model are compiled first.
*/
`timescale 1ns/100ps
module cawd_top_tb_top;
  // ----------------------------------------------------------------
  // Signals, clock and instances
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, clr = 1'b0;
  logic [7:0] adr_i = 8'h00, rd;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, wd_reset_o;
  logic [2:0] pin_o, clock_select_o;
  logic [15:0] hi_cnt [3];
  int fails = 0, check_count = 0, cycles = 0, n;

  always #5 clk_i = ~clk_i;

  cawd_top i_cawd_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cpu_idle_i(1'b0), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pin_o(pin_o), .clock_select_o(clock_select_o), .wd_reset_o(wd_reset_o));
  cawd_load_model i_cawd_load_model (.clk_i(clk_i), .clr_i(clr), .pin_i(pin_o), .hi_cnt_o(hi_cnt));

  // Compare, count and report
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One classic cycle; read data taken at the ack edge
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task rchk(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk({8'h0, rd}, {8'h0, exp});
  endtask

  task do_reset;
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // Bounded wait for the reset request pulse
  task wait_wd(input int lim);
    n = 0;
    while (wd_reset_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  // Count pin high cycles over len clocks
  task measure(input int len);
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (len) @(posedge clk_i);
    #1;
  endtask

  // Hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails++;
      close_out;
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset;
    wait_wd(400);
    chk({15'h0, n >= 256 && n <= 258}, 16'h1);
    @(posedge clk_i);
    chk({15'h0, wd_reset_o}, 16'h0);
    rchk(cawd_pkg::ADR_MODE, 8'h40);
    chk({13'h0, clock_select_o}, 16'h0);
    do_reset;
    wb(1'b1, cawd_pkg::ADR_MODE, 8'h4e);
    @(posedge clk_i);
    chk({13'h0, clock_select_o}, 16'h0);
    wb(1'b1, cawd_pkg::ADR_CNT_HI, 8'h80);
    rchk(cawd_pkg::ADR_CNT_HI, 8'h00);
    rchk(cawd_pkg::ADR_CTRL, 8'h00);
    wb(1'b1, cawd_pkg::ADR_CTRL, 8'h04);
    wait_wd(6);
    chk({15'h0, wd_reset_o}, 16'h1);
    // Clock select is frozen while enabled, so disable before selecting
    wb(1'b1, cawd_pkg::ADR_MODE, 8'h00);
    wb(1'b1, cawd_pkg::ADR_MODE, 8'h0e);
    @(posedge clk_i);
    chk({13'h0, clock_select_o}, 16'h7);
    wb(1'b1, cawd_pkg::ADR_MODE, 8'h20);
    wb(1'b1, cawd_pkg::ADR_MODE, 8'h00);
    wb(1'b1, cawd_pkg::ADR_CTRL, 8'h04);
    wait_wd(6);
    chk({15'h0, wd_reset_o}, 16'h1);
    do_reset;
    // Modulation setup with the watchdog off and the counter at zero
    wb(1'b1, cawd_pkg::ADR_MODE, 8'h00);
    wb(1'b1, cawd_pkg::ADR_CTRL, 8'h00);
    wb(1'b1, cawd_pkg::ADR_CNT_LO, 8'h00);
    wb(1'b1, cawd_pkg::ADR_CNT_HI, 8'h00);
    wb(1'b1, cawd_pkg::ADR_PWMCFG, 8'h00);
    for (int m = 0; m < 3; m++) wb(1'b1, cawd_pkg::ADR_MOD_BASE + 8'(4 * m), 8'h4a);
    wb(1'b1, cawd_pkg::ADR_CMPL_BASE, 8'hc0);
    wb(1'b1, cawd_pkg::ADR_CMPH_BASE, 8'hc0);
    wb(1'b1, cawd_pkg::ADR_CMPL_BASE + 8'h4, 8'h00);
    wb(1'b1, cawd_pkg::ADR_CMPH_BASE + 8'h4, 8'h00);
    wb(1'b1, cawd_pkg::ADR_CMPL_BASE + 8'h8, 8'h80);
    wb(1'b1, cawd_pkg::ADR_CTRL, 8'h40);
    // Let one low byte rollover pass so a zero compare has matched once
    repeat (256) @(posedge clk_i);
    measure(512);
    chk(hi_cnt[0], 16'd128);
    chk(hi_cnt[1], 16'd512);
    chk(hi_cnt[2], 16'd0);
    rchk(cawd_pkg::ADR_MOD_BASE + 8'h8, 8'h0a);
    rchk(cawd_pkg::ADR_CTRL, 8'h43);
    rchk(cawd_pkg::ADR_PWMCFG, 8'h20);
    wb(1'b1, cawd_pkg::ADR_CMPH_BASE, 8'h80);
    repeat (256) @(posedge clk_i);
    measure(512);
    chk(hi_cnt[0], 16'd256);
    // Half duty at 9, 10 and 11 bits through the reload register
    for (int k = 1; k < 4; k++) begin
      wb(1'b1, cawd_pkg::ADR_PWMCFG, 8'h80 | 8'(k));
      wb(1'b1, cawd_pkg::ADR_CMPL_BASE, 8'h00);
      wb(1'b1, cawd_pkg::ADR_CMPH_BASE, 8'h01 << (k - 1));
      rchk(cawd_pkg::ADR_CMPH_BASE, 8'h01 << (k - 1));
      // A full cycle must pass so the reload value reaches the comparator
      repeat (512 << k) @(posedge clk_i);
      measure(512 << k);
      chk(hi_cnt[0], 16'(256 << k));
    end
    wb(1'b1, cawd_pkg::ADR_PWMCFG, 8'h03);
    rchk(cawd_pkg::ADR_CMPH_BASE, 8'h04);
    // Full-width mode near the top of the count
    wb(1'b1, cawd_pkg::ADR_CTRL, 8'h00);
    wb(1'b1, cawd_pkg::ADR_CNT_HI, 8'hff);
    wb(1'b1, cawd_pkg::ADR_CNT_LO, 8'h00);
    wb(1'b1, cawd_pkg::ADR_MOD_BASE, 8'hca);
    wb(1'b1, cawd_pkg::ADR_CMPL_BASE, 8'h80);
    wb(1'b1, cawd_pkg::ADR_CMPH_BASE, 8'hff);
    wb(1'b1, cawd_pkg::ADR_CTRL, 8'h40);
    measure(300);
    chk(hi_cnt[0], 16'd128);
    chk({15'h0, pin_o[0]}, 16'h0);
    wb(1'b0, cawd_pkg::ADR_CTRL, 8'h00);
    chk({8'h0, rd & 8'h81}, 16'h0081);
    close_out;
  end
endmodule
